// ### shared/bfd_pkg.sv
package bfd_pkg;
   // =====================================
   // Timing
   localparam int CLK_PERIOD_NS = 50;
   localparam int TICK_PERIOD_NS = 1000000;
   localparam int TICK_CYCLES = (TICK_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int DLY_W = 16;
   // =====================================
   // Register map (byte addresses)
   localparam int ADDR_W = 8;
   localparam logic [7:0] CTRL_OFS = 8'h00;
   localparam logic [7:0] T_EARLY_OFS = 8'h04;
   localparam logic [7:0] T_MAIN_OFS = 8'h08;
   localparam logic [7:0] T_SLOW_OFS = 8'h0c;
   localparam logic [7:0] T_LOW_OFS = 8'h10;
   localparam logic [7:0] T_DROP_OFS = 8'h14;
   localparam logic [7:0] STATUS_OFS = 8'h18;
   localparam logic [2:0] LAST_IDX = 3'h6;
   // =====================================
   // Control fields
   localparam int CTRL_W = 11;
   localparam int SEAL_BIT = 0;
   localparam int CSUP_BIT = 1;
   localparam int INIT_LSB = 2;
   localparam int EARLY_LSB = 5;
   localparam int POS_LSB = 7;
   localparam int TEST_LSB = 9;
   localparam logic [10:0] CTRL_RST = 11'h000;
   // =====================================
   // Delay registers, milliseconds
   localparam int NUM_DLY = 5;
   localparam int TMR_EARLY = 0;
   localparam int TMR_MAIN = 1;
   localparam int TMR_SLOW = 2;
   localparam int TMR_LOW = 3;
   localparam int DLY_DROP = 4;
   localparam logic [15:0] T_EARLY_RST = 16'h004b;
   localparam logic [15:0] T_MAIN_RST = 16'h0096;
   localparam logic [15:0] T_SLOW_RST = 16'h01f4;
   localparam logic [15:0] T_LOW_RST = 16'h0000;
   localparam logic [15:0] T_DROP_RST = 16'hafc8;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : bfd_pkg

// ### design/bfd_core.sv
// The register offsets and the AXI4-Lite slave port are this design's own decisions.
`timescale 1ns/1ps
// Summary of operation
// [RQ1] Early, main and slow timed paths; any one declares failure.
// [RQ2] Early path fails on timeout with early contact closed and fault current.
// [RQ3] Main path fails on timeout if high-set current is still present.
// [RQ4] After main timeout plus low-set delay, low-set current still present fails.
// [RQ5] Early path ignores the low-set detector.
// [RQ6] Slow path fails on timeout with normally-open contact closed, no current check.
// [RQ7] Slow path is qualified by the in-test indication.
// [RQ8] Two outputs: re-trip and operate.
// [RQ9] Operate is held for a programmable seal-in time once asserted.
// [RQ10] Initiation is the OR of up to three selected initiate inputs.
// [RQ11] Optional seal-in of initiation while supervisory current persists.
// [RQ12] Optional current supervision: timers run only with supervisory current.
// [RQ13] Both early-position selections off disables the early path.
// [RQ14] Either selected early-position input shows the breaker closed.
// [RQ15] Position inputs combine redundantly; both off disables the slow path.
// [RQ16] Re-trip follows initiation without waiting for any timer.
// [RQ17] Either in-test indication disables the slow path; the code ignores any in-test input not selected in test_sel.
// [RQ18] Path delays programmable 0 to 60 s in 1 ms steps.
// [RQ19] Path timers clear whenever effective initiation drops.
// [RQ20] Timers advance on a 1 ms tick from the system clock.
module bfd_core #(
   parameter int TICK_CYCLES = bfd_pkg::TICK_CYCLES
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic [2:0] s_axi_awprot,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic [2:0] s_axi_arprot,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [2:0] init_in,
   input wire logic [1:0] early_opening_aux_contact,
   input wire logic [1:0] normally_open_aux_contact,
   input wire logic [1:0] in_test,
   input wire logic fault_det,
   input wire logic hiset_det,
   input wire logic loset_det,
   input wire logic supv_det,
   output logic retrip,
   output logic operate
);
   localparam int PW = $clog2(TICK_CYCLES + 1);
   localparam int DW = bfd_pkg::DLY_W;

   // =====================================
   // Register bus slave
   logic aw_held, w_held;
   logic [7:0] aw_addr_q;
   logic [31:0] w_data_q;
   logic [3:0] w_strb_q;
   logic [bfd_pkg::CTRL_W-1:0] ctrl;
   logic [DW-1:0] dly [bfd_pkg::NUM_DLY];
   logic [31:0] status;

   wire aw_take = s_axi_awvalid & s_axi_awready;
   wire w_take = s_axi_wvalid & s_axi_wready;
   wire ar_take = s_axi_arvalid & s_axi_arready;
   wire do_wr = aw_held & w_held & ~s_axi_bvalid;
   wire next_aw_held = aw_take | (aw_held & ~do_wr);
   wire next_w_held = w_take | (w_held & ~do_wr);
   wire next_rvalid = ar_take | (s_axi_rvalid & ~s_axi_rready);
   wire [2:0] wr_idx = aw_addr_q[4:2];
   wire [2:0] rd_idx = s_axi_araddr[4:2];
   wire wr_ok = (aw_addr_q[7:5] == 3'h0) && (wr_idx <= bfd_pkg::LAST_IDX);
   wire rd_ok = (s_axi_araddr[7:5] == 3'h0) && (rd_idx <= bfd_pkg::LAST_IDX);
   wire wr_ctrl = do_wr && ({aw_addr_q[7:2], 2'h0} == bfd_pkg::CTRL_OFS);
   logic [31:0] wr_val;

   // Read-modify-write for byte strobes; always_comb also wakes on what the functions read
   always_comb begin
      wr_val = merge(rd_mux(wr_idx), w_data_q, w_strb_q);
   end

   function automatic logic [31:0] merge(
      input logic [31:0] old_v,
      input logic [31:0] new_v,
      input logic [3:0] strb
   );
      logic [31:0] r;
      r = old_v;
      for (int b = 0; b < 4; b++) begin
         if (strb[b]) begin
            r[8*b +: 8] = new_v[8*b +: 8];
         end
      end
      return r;
   endfunction : merge

   function automatic logic [31:0] rd_mux(input logic [2:0] idx);
      logic [31:0] r;
      r = 32'h0000_0000;
      case (idx)
         3'h0: r = {21'h000000, ctrl};
         3'h6: r = status;
         3'h7: r = 32'h0000_0000;
         default: r = {16'h0000, dly[3'(idx - 3'h1)]};
      endcase
      return r;
   endfunction : rd_mux

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         aw_held <= 1'b0;
         w_held <= 1'b0;
         aw_addr_q <= 8'h00;
         w_data_q <= 32'h0000_0000;
         w_strb_q <= 4'h0;
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
      end else begin
         aw_held <= next_aw_held;
         w_held <= next_w_held;
         s_axi_awready <= ~next_aw_held;
         s_axi_wready <= ~next_w_held;
         if (aw_take) begin
            aw_addr_q <= s_axi_awaddr;
         end
         if (w_take) begin
            w_data_q <= s_axi_wdata;
            w_strb_q <= s_axi_wstrb;
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= bfd_pkg::RESP_OKAY;
      end else if (do_wr) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp <= wr_ok ? bfd_pkg::RESP_OKAY : bfd_pkg::RESP_SLVERR;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= bfd_pkg::RESP_OKAY;
      end else begin
         s_axi_arready <= ~next_rvalid;
         s_axi_rvalid <= next_rvalid;
         if (ar_take) begin
            s_axi_rdata <= rd_ok ? rd_mux(rd_idx) : 32'h0000_0000;
            s_axi_rresp <= rd_ok ? bfd_pkg::RESP_OKAY : bfd_pkg::RESP_SLVERR;
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ctrl <= bfd_pkg::CTRL_RST;
      end else if (wr_ctrl) begin
         ctrl <= wr_val[bfd_pkg::CTRL_W-1:0];
      end
   end

   // Delay registers at indices 1..5; status is read-only
   for (genvar d = 0; d < bfd_pkg::NUM_DLY; d++) begin : g_dly
      localparam logic [15:0] RST_V = (d == 0) ? bfd_pkg::T_EARLY_RST :
         (d == 1) ? bfd_pkg::T_MAIN_RST : (d == 2) ? bfd_pkg::T_SLOW_RST :
         (d == 3) ? bfd_pkg::T_LOW_RST : bfd_pkg::T_DROP_RST;
      // [RQ18] delay setting
      always_ff @(posedge clk or negedge rst_n) begin
         if (!rst_n) begin
            dly[d] <= RST_V;
         end else if (do_wr && wr_ok && wr_idx == 3'(d + 1)) begin
            dly[d] <= wr_val[DW-1:0];
         end
      end
   end

   // =====================================
   // Initiation
   wire seal_en = ctrl[bfd_pkg::SEAL_BIT];
   wire csup_en = ctrl[bfd_pkg::CSUP_BIT];
   wire [2:0] init_sel = ctrl[bfd_pkg::INIT_LSB +: 3];
   wire [1:0] early_sel = ctrl[bfd_pkg::EARLY_LSB +: 2];
   wire [1:0] pos_sel = ctrl[bfd_pkg::POS_LSB +: 2];
   wire [1:0] test_sel = ctrl[bfd_pkg::TEST_LSB +: 2];
   logic seal_q;
   // [RQ10] OR of selected initiates
   wire init_raw = |(init_in & init_sel);
   wire init_cmb = init_raw | seal_q;
   // [RQ12] current-supervised run
   wire run = init_cmb & (~csup_en | supv_det);
   wire next_seal = seal_en & supv_det & init_cmb;

   // [RQ11] seal-in latch
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         seal_q <= 1'b0;
      end else begin
         seal_q <= next_seal;
      end
   end

   // =====================================
   // Millisecond tick, free running so each delay lands within one tick
   logic [PW-1:0] pre;
   wire tick = (pre == PW'(TICK_CYCLES - 1));

   // [RQ20] tick prescaler
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pre <= '0;
      end else begin
         pre <= tick ? '0 : pre + 1'b1;
      end
   end

   // =====================================
   // Path timers: early, main, slow, and low-set after main
   logic [DW-1:0] cnt [4];
   logic [3:0] done;
   logic [3:0] tmr_run;
   for (genvar t = 0; t < 4; t++) begin : g_tmr
      if (t == bfd_pkg::TMR_LOW) begin : g_low
         // [RQ4] low-set delay starts at main timeout
         assign tmr_run[t] = run & done[bfd_pkg::TMR_MAIN];
      end else begin : g_path
         assign tmr_run[t] = run;
      end
      assign done[t] = tmr_run[t] & (cnt[t] >= dly[t]);
      // [RQ19] timers clear when initiation drops
      always_ff @(posedge clk or negedge rst_n) begin
         if (!rst_n) begin
            cnt[t] <= '0;
         end else if (!tmr_run[t]) begin
            cnt[t] <= '0;
         end else if (tick && cnt[t] != '1) begin
            cnt[t] <= cnt[t] + 1'b1;
         end
      end
   end

   // =====================================
   // Failure decisions
   // [RQ14] redundant early position
   wire early_closed = |(early_opening_aux_contact & early_sel);
   // [RQ15] redundant position
   wire pos_closed = |(normally_open_aux_contact & pos_sel);
   // [RQ17] in-test blocks slow path
   wire test_any = |(in_test & test_sel);
   // [RQ2] early path; [RQ5] no low-set input; [RQ13] off when unselected
   wire fail_early = done[bfd_pkg::TMR_EARLY] & early_closed & fault_det;
   // [RQ3] main path high-set
   wire fail_hi = done[bfd_pkg::TMR_MAIN] & hiset_det;
   // [RQ4] main contact failure
   wire fail_lo = done[bfd_pkg::TMR_LOW] & loset_det;
   // [RQ6] slow path; [RQ7] in-test qualified
   wire fail_slow = done[bfd_pkg::TMR_SLOW] & pos_closed & ~test_any;
   wire [3:0] fails = {fail_slow, fail_lo, fail_hi, fail_early};
   // [RQ1] any path declares failure
   wire any_fail = |fails;

   // =====================================
   // Outputs
   logic [DW-1:0] hold;
   wire [DW-1:0] next_hold = any_fail ? dly[bfd_pkg::DLY_DROP] :
      ((tick && hold != '0) ? hold - 1'b1 : hold);

   // [RQ8] re-trip and operate; [RQ16] re-trip on initiation
   // [RQ9] operate sealed for the dropout time
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         hold <= '0;
         operate <= 1'b0;
         retrip <= 1'b0;
      end else begin
         hold <= next_hold;
         operate <= any_fail | (next_hold != '0);
         retrip <= init_cmb;
      end
   end

   assign status = {20'h00000, fails, operate, retrip, run, init_cmb, 4'h0};

   // =====================================
   // Checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   sequence s_fail;
      any_fail;
   endsequence

   sequence s_op_seen;
      operate;
   endsequence

   a_operate_follows: assert property (s_fail |=> s_op_seen) // [RQ1]
      else $error("operate missing after failure");
   a_retrip_follow: assert property (init_cmb |=> retrip) // [RQ16]
      else $error("retrip did not follow initiation");
   a_retrip_clear: assert property (!init_cmb |=> !retrip) // [RQ8]
      else $error("retrip without initiation");
   a_early_disabled: assert property (early_sel == 2'h0 |-> !fail_early) // [RQ13]
      else $error("early path active while unselected");
   a_slow_in_test: assert property (test_any |-> !fail_slow) // [RQ17]
      else $error("slow path active in test");
   a_timer_reset: assert property (!run |=> cnt[0] == '0 && cnt[2] == '0) // [RQ19]
      else $error("timer not cleared");
   a_tick_period: assert property (tick |=> !tick) // [RQ20]
      else $error("tick longer than one cycle");
   a_seal_hold: assert property (operate && hold > 16'h0001 |=> operate) // [RQ9]
      else $error("operate dropped during seal-in");
   a_main_fail: assert property (done[1] && hiset_det |=> operate) // [RQ3]
      else $error("main path did not operate");
   a_low_start: assert property (!done[1] |-> !done[3]) // [RQ4]
      else $error("low-set ran before main timeout");
   a_seal_latch: assert property (seal_en && init_raw && supv_det ##1 // [RQ11]
      seal_en && supv_det |-> init_cmb)
      else $error("seal-in lost initiation");
   a_csup_block: assert property (csup_en && !supv_det |-> !run) // [RQ12]
      else $error("timers ran without current");
endmodule : bfd_core

// ### verif/bfd_breaker_model.sv
`timescale 1ns/1ps
// ==========================================
// Breaker with auxiliary contacts and detectors
module bfd_breaker_model #(
   parameter int OPEN_CYC = 8
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic trip,
   input wire logic close_cmd,
   input wire logic fault_on,
   input wire logic mech_ok,
   input wire logic arc_ok,
   output logic [1:0] early_contact,
   output logic [1:0] pos_contact,
   output logic fault_det,
   output logic hiset_det,
   output logic loset_det,
   output logic supv_det
);
   logic [7:0] cnt;
   logic moved;
   logic parted;
   logic cur;
   // Stays open once tripped, until the bench recloses it
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt <= 8'h00;
      end else if (close_cmd) begin
         cnt <= 8'h00;
      end else if (trip && cnt != 8'hff) begin
         cnt <= cnt + 8'h01;
      end
   end
   assign moved = mech_ok && (int'(cnt) >= OPEN_CYC);
   assign parted = moved && (int'(cnt) >= 2 * OPEN_CYC);
   // Resistor insertion drops only the high-set level; a failed interrupter keeps the rest
   assign cur = fault_on && !(parted && arc_ok);
   assign early_contact = {2{~moved}};
   assign pos_contact = {2{~parted}};
   assign fault_det = cur;
   assign hiset_det = fault_on && !parted;
   assign loset_det = cur;
   assign supv_det = cur;
endmodule : bfd_breaker_model

// ### verif/tb_top.sv
`timescale 1ns/1ps
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin error_cnt++; $display("wrong value t=%0t got %h exp %h", $time, (g), (e)); end end
module tb_top;
   localparam int TC = 4;
   localparam int WIN = 80;
   localparam int T_DROP = 12;
   int error_cnt = 0;
   int samples_checked = 0;
   logic clk, rst_n, awvalid, awready, wvalid, wready, bvalid, arvalid, arready, rvalid;
   logic [7:0] awaddr, araddr;
   logic [31:0] wdata, rdata;
   logic [1:0] bresp, rresp, early_c, pos_c, in_test;
   logic [2:0] init_in;
   logic [3:0] wstrb;
   logic fault_det, hiset_det, loset_det, supv_det, retrip, operate;
   logic close_cmd, fault_on, mech_ok, arc_ok;
   // ==========================================
   // Clock and instances
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   bfd_core #(.TICK_CYCLES(TC)) uut (
      .clk(clk), .rst_n(rst_n), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(1'b1),
      .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .s_axi_rvalid(rvalid), .s_axi_rready(1'b1), .init_in(init_in),
      .early_opening_aux_contact(early_c), .normally_open_aux_contact(pos_c),
      .in_test(in_test), .fault_det(fault_det), .hiset_det(hiset_det),
      .loset_det(loset_det), .supv_det(supv_det), .retrip(retrip), .operate(operate));
   bfd_breaker_model #(.OPEN_CYC(8)) pm (
      .clk(clk), .rst_n(rst_n), .trip(retrip), .close_cmd(close_cmd),
      .fault_on(fault_on), .mech_ok(mech_ok), .arc_ok(arc_ok),
      .early_contact(early_c), .pos_contact(pos_c), .fault_det(fault_det),
      .hiset_det(hiset_det), .loset_det(loset_det), .supv_det(supv_det));
   // ==========================================
   // Bus tasks
   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      int n = 0;
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      do begin
         @(posedge clk);
         n++;
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
      end while (!bvalid && n < 50);
      `CHK(bvalid, 1'b1)
      `CHK(bresp, er)
   endtask : axi_wr
   task automatic axi_rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
      int n = 0;
      araddr <= a;
      arvalid <= 1'b1;
      do begin
         @(posedge clk);
         n++;
         if (arready) arvalid <= 1'b0;
      end while (!rvalid && n < 50);
      `CHK(rvalid, 1'b1)
      `CHK(rdata, ed)
      `CHK(rresp, er)
   endtask : axi_rd
   function automatic logic [10:0] mk(input logic [1:0] sc, input logic [2:0] is,
         input logic [1:0] es, input logic [1:0] ps, input logic [1:0] ts);
      return {ts, ps, es, is, sc};
   endfunction : mk
   // ==========================================
   // Scenarios
   task automatic chk_regs();
      logic [15:0] rv [6];
      logic [15:0] nv [6];
      rv = '{16'h0000, bfd_pkg::T_EARLY_RST, bfd_pkg::T_MAIN_RST, bfd_pkg::T_SLOW_RST,
         bfd_pkg::T_LOW_RST, bfd_pkg::T_DROP_RST};
      nv = '{16'h0000, 16'h0006, 16'h000a, 16'h0010, 16'h0004, 16'(T_DROP)};
      axi_rd(bfd_pkg::CTRL_OFS, 32'h0, bfd_pkg::RESP_OKAY);
      // Upper half written ones must read back as zeros
      for (int i = 1; i < 6; i++) begin
         axi_rd(8'(4 * i), {16'h0000, rv[i]}, bfd_pkg::RESP_OKAY);
         axi_wr(8'(4 * i), {16'hffff, nv[i]}, bfd_pkg::RESP_OKAY);
         axi_rd(8'(4 * i), {16'h0000, nv[i]}, bfd_pkg::RESP_OKAY);
      end
      axi_rd(8'h1c, 32'h0, bfd_pkg::RESP_SLVERR);
      // An unmapped write must not alias onto the early delay
      axi_wr(8'h44, 32'hffffffff, bfd_pkg::RESP_SLVERR);
      axi_rd(bfd_pkg::T_EARLY_OFS, 32'h0000_0006, bfd_pkg::RESP_OKAY);
      axi_wr(bfd_pkg::STATUS_OFS, 32'h0, bfd_pkg::RESP_OKAY);
      axi_rd(bfd_pkg::STATUS_OFS, 32'h0, bfd_pkg::RESP_OKAY);
      // Lane 1 only: lane 0 of the low-set delay keeps its value
      wstrb <= 4'h2;
      axi_wr(bfd_pkg::T_LOW_OFS, 32'h0000_ab00, bfd_pkg::RESP_OKAY);
      axi_rd(bfd_pkg::T_LOW_OFS, 32'h0000_ab04, bfd_pkg::RESP_OKAY);
      wstrb <= 4'hf;
      axi_wr(bfd_pkg::T_LOW_OFS, 32'h0000_0004, bfd_pkg::RESP_OKAY);
   endtask : chk_regs
   // Operate time d in ms, 0 when no failure may be declared
   task automatic run_case(input logic [10:0] ctl, input logic [2:0] ini,
         input logic [2:0] mdl, input logic [1:0] tst, input int hold, input int d);
      int first = 0;
      axi_wr(bfd_pkg::CTRL_OFS, {21'h0, ctl}, bfd_pkg::RESP_OKAY);
      {mech_ok, arc_ok, fault_on} <= mdl;
      in_test <= tst;
      @(posedge clk);
      init_in <= ini;
      for (int i = 1; i <= WIN; i++) begin
         @(posedge clk);
         if (i == 2) `CHK(retrip, |(ini & ctl[bfd_pkg::INIT_LSB +: 3]))
         if (i == hold * TC) init_in <= 3'h0;
         if (i == WIN) fault_on <= 1'b0;
         if (operate === 1'b1 && first == 0) first = i;
      end
      `CHK(first != 0, d != 0)
      if (d != 0) begin
         `CHK(first >= (d - 2) * TC && first <= d * TC + 8, 1'b1)
         repeat ((T_DROP - 2) * TC) @(posedge clk);
         `CHK(operate, 1'b1)
         repeat (2 * TC + 10) @(posedge clk);
      end else begin
         // Initiation drops by the last window edge; retrip needs two edges to show it
         repeat (2) @(posedge clk);
      end
      `CHK(operate, 1'b0)
      `CHK(retrip, 1'b0)
      close_cmd <= 1'b1;
      @(posedge clk);
      close_cmd <= 1'b0;
   endtask : run_case
   task automatic give_verdict();
      $display("comparisons %0d mismatches %0d", samples_checked, error_cnt);
      if (error_cnt == 0 && samples_checked > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : give_verdict
   // ==========================================
   // Main sequence and watchdog
   initial begin
      {rst_n, awvalid, wvalid, arvalid, close_cmd, fault_on, mech_ok, arc_ok} = 8'h00;
      {awaddr, araddr, wdata, init_in, in_test} = 53'h0;
      wstrb = 4'hf;
      repeat (6) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      chk_regs();
      run_case(mk(2'h0, 3'h7, 2'h3, 2'h3, 2'h3), 3'h2, 3'h7, 2'h0, 20, 0);
      run_case(mk(2'h0, 3'h1, 2'h1, 2'h0, 2'h0), 3'h1, 3'h1, 2'h0, 20, 6);
      run_case(mk(2'h0, 3'h1, 2'h0, 2'h0, 2'h0), 3'h1, 3'h1, 2'h0, 20, 10);
      run_case(mk(2'h0, 3'h4, 2'h3, 2'h3, 2'h0), 3'h4, 3'h5, 2'h0, 20, 14);
      run_case(mk(2'h0, 3'h1, 2'h3, 2'h2, 2'h0), 3'h1, 3'h0, 2'h0, 20, 16);
      run_case(mk(2'h0, 3'h1, 2'h3, 2'h3, 2'h2), 3'h1, 3'h0, 2'h2, 20, 0);
      run_case(mk(2'h2, 3'h1, 2'h3, 2'h3, 2'h0), 3'h1, 3'h0, 2'h0, 20, 0);
      run_case(mk(2'h1, 3'h1, 2'h1, 2'h0, 2'h0), 3'h1, 3'h1, 2'h0, 2, 6);
      run_case(mk(2'h0, 3'h1, 2'h1, 2'h0, 2'h0), 3'h1, 3'h1, 2'h0, 2, 0);
      run_case(mk(2'h0, 3'h1, 2'h1, 2'h0, 2'h0), 3'h6, 3'h1, 2'h0, 20, 0);
      give_verdict();
   end
   // Whole run is near 1200 cycles; over sixteen times that means a hang
   initial begin
      repeat (20000) @(posedge clk);
      error_cnt++;
      give_verdict();
   end
endmodule : tb_top
